// >>> shared/sleep_pkg.sv
// Purpose: Shared constants for the sleep and power-mode controller
// Assumes: 10 MHz system clock
// Notes:   Timer figures are counted in millisecond ticks
`default_nettype none

package sleep_pkg;

    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          TICK_PERIOD_NS = 1_000_000;
    localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    localparam int          MODE_W         = 3;
    localparam logic [2:0]  MODE_NORMAL    = 3'h0;
    localparam logic [2:0]  MODE_PIN       = 3'h1;
    localparam logic [2:0]  MODE_CYCLIC    = 3'h4;
    localparam logic [2:0]  MODE_CYC_PIN   = 3'h5;

    localparam int          OPT_W          = 8;
    localparam int          OPT_PSM_BIT    = 3;

    localparam int          TMR_W          = 16;
    localparam logic [15:0] RADIO_HOLD_MS  = 16'h000A;

    localparam int          CAUSE_W        = 2;
    localparam logic [1:0]  CAUSE_NONE     = 2'h0;
    localparam logic [1:0]  CAUSE_PIN      = 2'h1;
    localparam logic [1:0]  CAUSE_TIMER    = 2'h2;
    localparam logic [1:0]  CAUSE_EDGE     = 2'h3;

    localparam logic        CTS_N_RESET    = 1'b0;

    typedef enum logic [1:0] {
        ST_AWAKE,
        ST_PREP,
        ST_CLOSE,
        ST_ASLEEP
    } sleep_state_t;

endpackage

`default_nettype wire

// >>> verilog/tick_timer.sv
// Purpose: Loadable down-counter of millisecond ticks
// Assumes: Tick is a one-cycle pulse
// Notes:   Expired pulses once when the count reaches zero while running
`default_nettype none

module tick_timer (
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    input  wire logic                     tick,
    input  wire logic                     load,
    input  wire logic [sleep_pkg::TMR_W-1:0] load_value,
    input  wire logic                     run,
    output logic                          expired
);
    import sleep_pkg::*;

    logic [TMR_W-1:0] count_q;
    logic [TMR_W-1:0] count_d;
    logic             armed_q;
    logic             armed_d;
    logic             hit;

    assign hit     = run && armed_q && tick && (count_q <= 16'h0001);
    assign count_d = load ? load_value : ((run && tick && count_q != '0) ? count_q - 16'h0001 : count_q);
    assign armed_d = load ? 1'b1 : (hit ? 1'b0 : armed_q);
    assign expired = hit && !load;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
            armed_q <= 1'b0;
        end else begin
            count_q <= count_d;
            armed_q <= armed_d;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/radio_power_ctrl.sv
// Purpose: Power state of the radio subsystem
// Assumes: Tick is a one-cycle millisecond pulse
// Notes:   Awake window restarts on every wake event
`default_nettype none

module radio_power_ctrl (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic tick,
    input  wire logic airplane_setting,
    input  wire logic radio_power_saving,
    input  wire logic deep_sleep,
    input  wire logic net_timer_event,
    input  wire logic host_net_activity,
    output logic      radio_power_en,
    output logic      radio_low_power,
    output logic      network_allow
);
    import sleep_pkg::*;

    logic [TMR_W-1:0] hold_q;
    logic [TMR_W-1:0] hold_d;
    logic             wake_evt;
    logic             psm_active;
    logic             power_d;
    logic             low_d;
    logic             allow_d;
    logic             power_q;
    logic             low_q;
    logic             allow_q;

    assign psm_active = radio_power_saving && !airplane_setting;                        // [RULE16]
    assign wake_evt   = psm_active && (net_timer_event || host_net_activity);            // [RULE17]
    assign hold_d     = wake_evt ? RADIO_HOLD_MS
                      : ((tick && hold_q != '0) ? hold_q - 16'h0001 : hold_q);           // [RULE17]
    assign power_d    = !airplane_setting && (psm_active || !deep_sleep);               // [RULE15] [RULE14] [RULE18]
    assign low_d      = psm_active && !wake_evt && hold_q == '0;                         // [RULE18]
    assign allow_d    = !airplane_setting && power_d;                                   // [RULE15]

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hold_q  <= '0;
            power_q <= 1'b0;
            low_q   <= 1'b0;
            allow_q <= 1'b0;
        end else begin
            hold_q  <= hold_d;
            power_q <= power_d;
            low_q   <= low_d;
            allow_q <= allow_d;
        end
    end

    assign radio_power_en  = power_q;
    assign radio_low_power = low_q;
    assign network_allow   = allow_q;

endmodule

`default_nettype wire

// >>> verilog/sleep_mode_controller.sv
// Functional notes
// RULE1: Selector 0, the reset default, keeps the device always awake.
// RULE2: Selector 1 sleeps and wakes only by the active sleep control pin.
// RULE3: Request pin high: finish transfers, close connections, then enter low power.
// RULE4: Request pin low: leave pin sleep and return awake.
// RULE5: Selector 4 alternates a timed sleep with a short awake poll.
// RULE6: With flow control in cyclic sleep, clear-to-send low awake, high asleep.
// RULE7: Selector 5 is cyclic sleep plus early wake on request pin falling edge.
// RULE8: Request pin controls pin sleep by default, for UART or SPI.
// RULE9: Request pin rules if configured; else select pin if configured.
// RULE10: Select pin low wakes or keeps awake; high sends to sleep.
// RULE11: Neither pin configured in selector 1: stay awake.
// RULE12: Preparation starts at once; early release only skips final low-power entry.
// RULE13: Sleep timer starts on wake, restarts on reconfiguration; expiry returns to sleep.
// RULE14: Deep sleep closes datagram links, powers radio off; exit resumes processing.
// RULE15: Airplane setting keeps radio off and blocks network access.
// RULE16: Radio power saving only while device option bit 3 is set.
// RULE17: Power saving radio wakes on network timers or host activity, then returns.
// RULE18: Power saving keeps radio low-power, not unpowered, during module sleep.
// RULE19: Other selector values act as always awake.
//
// Purpose: Sleep and power-mode controller of a cellular modem module
// Assumes: All inputs synchronous to clk_sys
// Notes:   Timer periods are in millisecond ticks
`default_nettype none

module sleep_mode_controller #(
    parameter int TICK_CYCLES = sleep_pkg::TICK_CYCLES
) (
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    input  wire logic [sleep_pkg::MODE_W-1:0] sleep_mode_select,
    input  wire logic                        sleep_pin_cfg,
    input  wire logic                        select_pin_cfg,
    input  wire logic                        flow_ctrl_pin_cfg,
    input  wire logic [sleep_pkg::OPT_W-1:0] device_options,
    input  wire logic                        airplane_setting,
    input  wire logic                        sleep_request_pin,
    input  wire logic                        spi_select_pin,
    input  wire logic [sleep_pkg::TMR_W-1:0] sleep_period,
    input  wire logic [sleep_pkg::TMR_W-1:0] awake_period,
    input  wire logic                        cfg_write,
    input  wire logic                        xfer_busy,
    input  wire logic                        conn_active,
    input  wire logic                        net_timer_event,
    input  wire logic                        host_net_activity,
    output logic                             cts_n,
    output logic                             sleep_prep,
    output logic                             close_conn_req,
    output logic                             low_power,
    output logic                             proc_suspend,
    output logic                             proc_resume,
    output logic [1:0]                       sleep_state,
    output logic [sleep_pkg::CAUSE_W-1:0]    wake_cause,
    output logic                             radio_power_en,
    output logic                             radio_low_power,
    output logic                             network_allow
);
    import sleep_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    logic [TICK_W-1:0] tick_cnt_q;
    logic [TICK_W-1:0] tick_cnt_d;
    logic              tick;

    assign tick       = tick_cnt_q == TICK_W'(TICK_CYCLES - 1);
    assign tick_cnt_d = tick ? '0 : tick_cnt_q + TICK_W'(1);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    logic mode_pin;
    logic mode_cyclic;
    logic mode_pinwake;
    logic mode_awake;

    assign mode_pin     = sleep_mode_select == MODE_PIN;                               // [RULE2]
    assign mode_pinwake = sleep_mode_select == MODE_CYC_PIN;                           // [RULE7]
    assign mode_cyclic  = sleep_mode_select == MODE_CYCLIC || mode_pinwake;            // [RULE5] [RULE7]
    assign mode_awake   = !mode_pin && !mode_cyclic;                                   // [RULE1] [RULE19]

    ////////////////////////////////////////////////////////////////////////////
    // Control pin selection

    logic use_request_pin;
    logic use_select_pin;
    logic pin_sleep_level;

    assign use_request_pin = sleep_pin_cfg;                                            // [RULE8] [RULE9]
    assign use_select_pin  = !sleep_pin_cfg && select_pin_cfg;                         // [RULE9]
    assign pin_sleep_level = use_request_pin ? sleep_request_pin                       // [RULE3] [RULE4]
                           : (use_select_pin ? spi_select_pin : 1'b0);                 // [RULE10] [RULE11]

    logic pin_want_sleep;

    assign pin_want_sleep = mode_pin && pin_sleep_level;                               // [RULE2]

    ////////////////////////////////////////////////////////////////////////////
    // Request pin falling edge

    logic req_prev_q;
    logic req_fall;

    assign req_fall = req_prev_q && !sleep_request_pin;                                // [RULE7]

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_prev_q <= 1'b0;
        end else begin
            req_prev_q <= sleep_request_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State machine

    sleep_state_t state_q;
    sleep_state_t state_d;

    logic awake_tmr_exp;
    logic period_tmr_exp;
    logic enter_awake;
    logic enter_asleep;
    logic wake_now;
    logic abort_entry;
    logic [CAUSE_W-1:0] cause_d;

    // Early pin release or a change to an always-awake selector only cancels the final low-power step
    assign abort_entry = mode_pin ? !pin_sleep_level : !mode_cyclic;                   // [RULE12]

    assign wake_now = mode_awake                                                       // [RULE1] [RULE19]
                   || (mode_pin && !pin_sleep_level)                                   // [RULE4] [RULE10] [RULE11]
                   || (mode_cyclic && period_tmr_exp)                                  // [RULE5]
                   || (mode_pinwake && req_fall);                                      // [RULE7]

    always_comb begin
        state_d = state_q;
        cause_d = CAUSE_NONE;
        unique case (state_q)
            ST_AWAKE: begin
                if (pin_want_sleep) begin
                    state_d = ST_PREP;                                                 // [RULE3] [RULE12]
                end else if (mode_cyclic && awake_tmr_exp) begin
                    state_d = ST_PREP;                                                 // [RULE13]
                end
            end
            ST_PREP: begin
                if (!xfer_busy) begin
                    state_d = ST_CLOSE;                                                // [RULE3]
                end
            end
            ST_CLOSE: begin
                if (!conn_active) begin
                    state_d = abort_entry ? ST_AWAKE : ST_ASLEEP;                      // [RULE3] [RULE12]
                end
            end
            ST_ASLEEP: begin
                if (wake_now) begin
                    state_d = ST_AWAKE;
                    if (mode_pinwake && req_fall) begin
                        cause_d = CAUSE_EDGE;
                    end else if (mode_cyclic && period_tmr_exp) begin
                        cause_d = CAUSE_TIMER;
                    end else begin
                        cause_d = CAUSE_PIN;
                    end
                end
            end
        endcase
    end

    assign enter_awake  = state_q != ST_AWAKE && state_d == ST_AWAKE;
    assign enter_asleep = state_q != ST_ASLEEP && state_d == ST_ASLEEP;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_AWAKE;                                                       // [RULE1]
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep timer and sleep period timer

    logic awake_load;

    assign awake_load = enter_awake || cfg_write;                                      // [RULE13]

    tick_timer u_awake_timer (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .tick       (tick),
        .load       (awake_load),
        .load_value (awake_period),
        .run        (state_q == ST_AWAKE && mode_cyclic),
        .expired    (awake_tmr_exp)
    );

    tick_timer u_period_timer (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .tick       (tick),
        .load       (enter_asleep || cfg_write),
        .load_value (sleep_period),
        .run        (state_q == ST_ASLEEP && mode_cyclic),
        .expired    (period_tmr_exp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic       cts_n_q;
    logic       cts_n_d;
    logic       prep_q;
    logic       close_q;
    logic       low_q;
    logic       resume_q;
    logic [1:0] cause_q;
    logic       cyc_flow;

    assign cyc_flow = flow_ctrl_pin_cfg && mode_cyclic;
    assign cts_n_d  = cyc_flow ? (state_d != ST_AWAKE) : CTS_N_RESET;                  // [RULE6]

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cts_n_q  <= CTS_N_RESET;
            prep_q   <= 1'b0;
            close_q  <= 1'b0;
            low_q    <= 1'b0;
            resume_q <= 1'b0;
            cause_q  <= CAUSE_NONE;
        end else begin
            cts_n_q  <= cts_n_d;
            prep_q   <= state_d == ST_PREP || state_d == ST_CLOSE;                    // [RULE12]
            close_q  <= state_d == ST_CLOSE;                                           // [RULE3] [RULE14]
            low_q    <= state_d == ST_ASLEEP;                                          // [RULE3]
            resume_q <= state_q == ST_ASLEEP && state_d == ST_AWAKE;                   // [RULE14]
            cause_q  <= (cause_d != CAUSE_NONE) ? cause_d : cause_q;
        end
    end

    assign cts_n          = cts_n_q;
    assign sleep_prep     = prep_q;
    assign close_conn_req = close_q;
    assign low_power      = low_q;
    assign proc_suspend   = low_q;                                                     // [RULE14]
    assign proc_resume    = resume_q;
    assign sleep_state    = state_q;
    assign wake_cause     = cause_q;

    ////////////////////////////////////////////////////////////////////////////
    // Radio subsystem power

    radio_power_ctrl u_radio (
        .clk_sys            (clk_sys),
        .arst_n             (arst_n),
        .tick               (tick),
        .airplane_setting   (airplane_setting),
        .radio_power_saving (device_options[OPT_PSM_BIT]),                             // [RULE16]
        .deep_sleep         (low_q),                                                   // [RULE14] [RULE18]
        .net_timer_event    (net_timer_event),
        .host_net_activity  (host_net_activity),
        .radio_power_en     (radio_power_en),
        .radio_low_power    (radio_low_power),
        .network_allow      (network_allow)
    );

endmodule

`default_nettype wire

// >>> verif/host_model.sv
// Purpose: Host side that drives the sleep control pins
// Assumes: Bench sets want_sleep just after a clock edge
// Notes:   An unused request line toggles every cycle
`default_nettype none

module host_model (
    input  wire logic clk_sys,
    input  wire logic want_sleep,
    input  wire logic use_spi,
    output logic      sleep_request_pin,
    output logic      spi_select_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic tog_q = 1'b0;
    always @(posedge clk_sys) begin
        tog_q <= !tog_q;
    end
    // High asks for sleep, low wakes
    assign sleep_request_pin = use_spi ? tog_q : want_sleep;
    // Select idles high when not in use
    assign spi_select_pin    = use_spi ? want_sleep : 1'b1;
endmodule

`default_nettype wire

// >>> verif/sleep_mode_controller_asserts.sv
// Purpose: Port checks of the sleep controller
// Assumes: One clock domain
// Notes:   Bound into every controller instance
`default_nettype none

module sleep_chk #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic [2:0] sleep_mode_select,
    input wire logic       sleep_pin_cfg,
    input wire logic       select_pin_cfg,
    input wire logic       flow_ctrl_pin_cfg,
    input wire logic [7:0] device_options,
    input wire logic       airplane_setting,
    input wire logic       sleep_request_pin,
    input wire logic       spi_select_pin,
    input wire logic       xfer_busy,
    input wire logic       cts_n,
    input wire logic       sleep_prep,
    input wire logic       close_conn_req,
    input wire logic       low_power,
    input wire logic       proc_suspend,
    input wire logic       proc_resume,
    input wire logic [1:0] sleep_state,
    input wire logic       radio_power_en,
    input wire logic       radio_low_power,
    input wire logic       network_allow
);
    timeunit 1ns;
    timeprecision 1ns;
    import sleep_pkg::*;
    wire logic normal_mode;
    wire logic cyclic;
    wire logic pin_mode;
    wire logic psm_on;
    assign normal_mode = !(sleep_mode_select inside {MODE_PIN, MODE_CYCLIC, MODE_CYC_PIN});
    assign cyclic      = sleep_mode_select inside {MODE_CYCLIC, MODE_CYC_PIN};
    assign pin_mode    = sleep_mode_select == MODE_PIN;
    assign psm_on      = device_options[OPT_PSM_BIT];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    AST_AWAKE: assert property (sleep_state == 2'h0 && normal_mode |=> sleep_state == 2'h0)
        else $error("left awake in normal mode");
    AST_PIN_IN: assert property (pin_mode && sleep_pin_cfg && sleep_request_pin && sleep_state == 2'h0
        |=> sleep_state == 2'h1 && sleep_prep) else $error("no entry on request pin");
    AST_SEL_IN: assert property (pin_mode && !sleep_pin_cfg && select_pin_cfg && spi_select_pin
        && sleep_state == 2'h0 |=> sleep_state == 2'h1) else $error("no entry on select pin");
    AST_NO_PIN: assert property (pin_mode && !sleep_pin_cfg && !select_pin_cfg && sleep_state == 2'h0
        |=> sleep_state == 2'h0) else $error("slept with no control pin");
    AST_PREP: assert property (sleep_state == 2'h1 |=> sleep_state == ($past(xfer_busy) ? 2'h1 : 2'h2))
        else $error("wrong step out of preparation");
    AST_CLOSE: assert property (sleep_state == 2'h2 |-> close_conn_req && sleep_prep)
        else $error("teardown request missing");
    AST_WAKE: assert property (sleep_state == 2'h3 && pin_mode && sleep_pin_cfg && !sleep_request_pin
        |=> sleep_state == 2'h0 && proc_resume) else $error("no wake on pin low");
    AST_EDGE: assert property (sleep_state == 2'h3 && sleep_mode_select == MODE_CYC_PIN && sleep_pin_cfg
        && $fell(sleep_request_pin) |=> sleep_state == 2'h0) else $error("no wake on falling edge");
    AST_SUSP: assert property (low_power == (sleep_state == 2'h3) && proc_suspend == low_power)
        else $error("suspend not tied to sleep");
    AST_RESUME: assert property (proc_resume |-> $past(sleep_state) == 2'h3 ##1 !proc_resume)
        else $error("bad resume pulse");
    AST_CTS_CYC: assert property (flow_ctrl_pin_cfg && cyclic |=> cts_n == (sleep_state != 2'h0))
        else $error("clear-to-send wrong in cyclic sleep");
    AST_CTS_OFF: assert property (!flow_ctrl_pin_cfg |=> !cts_n)
        else $error("clear-to-send high without flow control");
    AST_AIR: assert property (airplane_setting |=> !radio_power_en && !network_allow)
        else $error("radio on in airplane setting");
    AST_PSM_OFF: assert property (!psm_on |=> !radio_low_power)
        else $error("radio low power without option bit");
    AST_PSM_PWR: assert property (psm_on && !airplane_setting |=> radio_power_en)
        else $error("radio unpowered with power saving");
endmodule

bind sleep_mode_controller sleep_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Directed test of the sleep and power-mode controller
// Assumes: Shortened tick of 4 clocks
// Notes:   Host pins come from the host model
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import sleep_pkg::*;
    localparam int TICK = 4;
    logic        clk_sys = 1'b0, arst_n = 1'b0, want_sleep = 1'b1, use_spi = 1'b0;
    logic [2:0]  sleep_mode_select = 3'h0;
    logic        sleep_pin_cfg = 1'b1, select_pin_cfg = 1'b1, flow_ctrl_pin_cfg = 1'b0;
    logic [7:0]  device_options = 8'h00;
    logic        airplane_setting = 1'b0, cfg_write = 1'b0, xfer_busy = 1'b1, conn_active = 1'b1;
    logic [15:0] sleep_period = 16'h0003, awake_period = 16'h0002;
    logic        net_timer_event = 1'b0, host_net_activity = 1'b0;
    logic        sleep_request_pin, spi_select_pin, cts_n, sleep_prep, close_conn_req, low_power;
    logic        proc_suspend, proc_resume, radio_power_en, radio_low_power, network_allow;
    logic [1:0]  sleep_state, wake_cause;
    int          failures = 0, n_tests = 0, n;

    sleep_mode_controller #(.TICK_CYCLES(TICK)) i_dut (.*);
    host_model i_host (.*);

    always #50 clk_sys = !clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic at_edge;
        @(posedge clk_sys);
    endtask
    task automatic look(input int k);
        repeat (k) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic wait_st(input logic [1:0] s, input int max);
        n = 0;
        while (sleep_state !== s && n < max) begin
            @(negedge clk_sys);
            n++;
        end
        check(sleep_state, s);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk_sys);
        failures++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        look(0);
        check(wake_cause, CAUSE_NONE);
        look(1);
        check({radio_power_en, network_allow}, 2'h3);
        for (int m = 0; m < 8; m++) begin
            if (!(m inside {1, 4, 5})) begin
                at_edge();
                sleep_mode_select <= m[2:0];
                look(6);
                check(sleep_state, 2'h0);
            end
        end
        at_edge();
        sleep_mode_select <= MODE_PIN;
        look(1);
        check(sleep_prep, 1'b1);
        look(3);
        check(sleep_state, 2'h1);
        at_edge();
        xfer_busy <= 1'b0;
        look(1);
        check(close_conn_req, 1'b1);
        look(2);
        check(sleep_state, 2'h2);
        at_edge();
        conn_active <= 1'b0;
        look(1);
        check(proc_suspend, 1'b1);
        look(1);
        check(radio_power_en, 1'b0);
        at_edge();
        want_sleep <= 1'b0;
        look(1);
        check(sleep_state, 2'h0);
        check(proc_resume, 1'b1);
        check(wake_cause, CAUSE_PIN);
        look(1);
        check(proc_resume, 1'b0);
        at_edge();
        xfer_busy <= 1'b1;
        conn_active <= 1'b1;
        want_sleep <= 1'b1;
        at_edge();
        want_sleep <= 1'b0;
        look(2);
        check(sleep_state, 2'h1);
        at_edge();
        xfer_busy <= 1'b0;
        look(0);
        at_edge();
        conn_active <= 1'b0;
        look(1);
        check(sleep_state, 2'h0);
        check(low_power, 1'b0);
        at_edge();
        sleep_pin_cfg <= 1'b0;
        use_spi <= 1'b1;
        want_sleep <= 1'b1;
        wait_st(2'h3, 10);
        at_edge();
        want_sleep <= 1'b0;
        wait_st(2'h0, 4);
        at_edge();
        select_pin_cfg <= 1'b0;
        use_spi <= 1'b0;
        want_sleep <= 1'b1;
        look(6);
        check(sleep_state, 2'h0);
        at_edge();
        sleep_pin_cfg <= 1'b1;
        want_sleep <= 1'b0;
        sleep_mode_select <= MODE_CYCLIC;
        flow_ctrl_pin_cfg <= 1'b1;
        cfg_write <= 1'b1;
        at_edge();
        cfg_write <= 1'b0;
        wait_st(2'h3, 40);
        check(cts_n, 1'b1);
        wait_st(2'h0, 40);
        check(n >= 2 * TICK && n <= 4 * TICK, 1'b1);
        check(wake_cause, CAUSE_TIMER);
        check(cts_n, 1'b0);
        wait_st(2'h3, 40);
        at_edge();
        sleep_mode_select <= MODE_CYC_PIN;
        sleep_period <= 16'h0100;
        want_sleep <= 1'b1;
        cfg_write <= 1'b1;
        at_edge();
        cfg_write <= 1'b0;
        look(2);
        at_edge();
        want_sleep <= 1'b0;
        wait_st(2'h0, 3);
        check(wake_cause, CAUSE_EDGE);
        at_edge();
        sleep_mode_select <= MODE_NORMAL;
        flow_ctrl_pin_cfg <= 1'b0;
        device_options <= 8'h08;
        wait_st(2'h0, 20);
        look(2);
        check(radio_low_power, 1'b1);
        for (int e = 0; e < 2; e++) begin
            at_edge();
            net_timer_event <= (e == 0);
            host_net_activity <= (e == 1);
            at_edge();
            net_timer_event <= 1'b0;
            host_net_activity <= 1'b0;
            look(0);
            check(radio_low_power, 1'b0);
            n = 0;
            while (radio_low_power !== 1'b1 && n < 80) begin
                @(negedge clk_sys);
                n++;
            end
            check(n >= 9 * TICK && n <= 11 * TICK + 2, 1'b1);
        end
        at_edge();
        sleep_mode_select <= MODE_PIN;
        want_sleep <= 1'b1;
        wait_st(2'h3, 10);
        look(1);
        check({radio_power_en, radio_low_power}, 2'h3);
        at_edge();
        airplane_setting <= 1'b1;
        look(1);
        check({radio_power_en, network_allow}, 2'h0);
        at_edge();
        airplane_setting <= 1'b0;
        device_options <= 8'hF7;
        want_sleep <= 1'b0;
        look(2);
        check(radio_low_power, 1'b0);
        conclude();
    end
endmodule

`default_nettype wire
